// *** verilog/async_timer_phase_correct_pwm.sv ***
// 8-bit timer, phase-correct pwm, asynchronous oscillator clocking, apb slave
`timescale 1ns/10ps

module async_timer_phase_correct_pwm (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator pin and sleep control
  input wire logic timer_osc_input,
  input wire logic sleep_active,
  input wire logic osc_halt,
  output logic wake_req,
  output logic cpu_stall,
  // compare output pins
  output logic [1:0] compare_outputs,
  output logic [1:0] compare_outputs_oe_n
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic tosc_s1_reg;
  logic tosc_s2_reg;
  logic tosc_s3_reg;
  logic tosc_rise;
  logic src_en;
  logic tick;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic psr_hit;
  logic async_sel_reg;
  logic [9:0] psc_reg;
  logic [9:0] psc_mask;
  logic [7:0] hold_reg [timer_async_pkg::N_HOLD];
  logic [1:0] edge_reg [timer_async_pkg::N_HOLD];
  logic [7:0] commit_val [timer_async_pkg::N_HOLD];
  logic [timer_async_pkg::N_HOLD-1:0] busy_reg;
  logic [timer_async_pkg::N_HOLD-1:0] commit;
  logic [timer_async_pkg::N_HOLD-1:0] wr_hit;
  timer_async_pkg::ctrl_a_t ctrl_a_reg;
  timer_async_pkg::ctrl_b_t ctrl_b_reg;
  logic [7:0] cmp_reg [2];
  logic [7:0] act_reg [2];
  logic [1:0] com [2];
  logic [1:0] match;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] cnt_rd_reg;
  logic [7:0] top;
  logic down_reg;
  logic down_next;
  logic pc_mode;
  logic at_top;
  logic [2:0] wgm;
  logic [2:0] ev;
  logic [2:0] ev_cpu;
  logic [2:0] flag_reg;
  logic [2:0] ien_reg;
  logic [2:0] pipe_reg [timer_async_pkg::FLAG_SYNC_CYCLES];
  logic [1:0] dir_reg;
  logic [2:0] stall_reg;
  logic wake_arm_reg;
  logic [7:0] rd_mux;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // oscillator pin synchroniser
  // ----------------------------------------
  // edge detect relies on the cpu clock being well above the oscillator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tosc_s1_reg <= 1'b0;
      tosc_s2_reg <= 1'b0;
      tosc_s3_reg <= 1'b0;
    end else begin
      tosc_s1_reg <= timer_osc_input;
      tosc_s2_reg <= tosc_s1_reg;
      tosc_s3_reg <= tosc_s2_reg;
    end
  end
  assign tosc_rise = tosc_s2_reg & ~tosc_s3_reg;

  // ----------------------------------------
  // source clock and prescaler
  // ----------------------------------------
  // oscillator source frozen whenever osc_halt is high in asynchronous mode
  assign src_en = ~(async_sel_reg & osc_halt) & (async_sel_reg ? tosc_rise : 1'b1);
  assign psc_mask = timer_async_pkg::PSC_MASK[ctrl_b_reg.prescale_select];
  assign tick = src_en & (ctrl_b_reg.prescale_select != 3'h0) & ((psc_reg & psc_mask) == psc_mask);
  assign psr_hit = wr_acc && (paddr == timer_async_pkg::OFF_GTC) && pwdata[timer_async_pkg::PSR_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_reg <= 10'h000;
    end else if (psr_hit) begin
      psc_reg <= 10'h000;
    end else if (src_en) begin
      psc_reg <= psc_reg + 10'h001;
    end
  end

  a_prescaler_clear: assert property (psr_hit |=> psc_reg == 10'h000)
    else $error("prescaler not cleared by reset bit");

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // zero wait: ready in the first access cycle
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= timer_async_pkg::OFF_DIR);

  always_comb begin
    case (paddr)
      timer_async_pkg::OFF_CTRL_A: rd_mux = ctrl_a_reg;
      timer_async_pkg::OFF_CTRL_B: rd_mux = ctrl_b_reg;
      timer_async_pkg::OFF_COUNTER: rd_mux = cnt_rd_reg;
      timer_async_pkg::OFF_CMP_A: rd_mux = cmp_reg[0];
      timer_async_pkg::OFF_CMP_B: rd_mux = cmp_reg[1];
      timer_async_pkg::OFF_ASYNC: rd_mux = {2'h0, async_sel_reg, busy_reg};
      timer_async_pkg::OFF_FLAGS: rd_mux = {5'h00, flag_reg};
      timer_async_pkg::OFF_IEN: rd_mux = {5'h00, ien_reg};
      timer_async_pkg::OFF_DIR: rd_mux = {6'h00, dir_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ----------------------------------------
  // directly written configuration
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      async_sel_reg <= 1'b0;
      ien_reg <= 3'h0;
      dir_reg <= 2'h0;
    end else if (wr_acc) begin
      if (paddr == timer_async_pkg::OFF_ASYNC) begin
        async_sel_reg <= pwdata[timer_async_pkg::ASYNC_SEL_BIT];
      end
      if (paddr == timer_async_pkg::OFF_IEN) begin
        ien_reg <= pwdata[2:0];
      end
      if (paddr == timer_async_pkg::OFF_DIR) begin
        dir_reg <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // holding registers and update-busy bits
  // ----------------------------------------
  // a second write while busy restarts the transfer with the new value
  for (genvar i = 0; i < timer_async_pkg::N_HOLD; i++) begin : g_hold
    assign wr_hit[i] = wr_acc && (paddr == timer_async_pkg::HOLD_OFF[i]);
    assign commit[i] = async_sel_reg ?
      (busy_reg[i] & tosc_rise & (edge_reg[i] == timer_async_pkg::COMMIT_EDGES - 2'h1)) : wr_hit[i];
    assign commit_val[i] = async_sel_reg ? hold_reg[i] : pwdata[7:0];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        hold_reg[i] <= timer_async_pkg::RST_BYTE;
        busy_reg[i] <= 1'b0;
        edge_reg[i] <= 2'h0;
      end else if (wr_hit[i] && async_sel_reg) begin
        hold_reg[i] <= pwdata[7:0];
        busy_reg[i] <= 1'b1;
        edge_reg[i] <= 2'h0;
      end else if (commit[i] || !async_sel_reg) begin
        busy_reg[i] <= 1'b0;
      end else if (busy_reg[i] && tosc_rise) begin
        edge_reg[i] <= edge_reg[i] + 2'h1;
      end
    end
  end

  a_busy_on_write: assert property (wr_hit[timer_async_pkg::IDX_CMP_A] && async_sel_reg
    |=> busy_reg[timer_async_pkg::IDX_CMP_A])
    else $error("compare busy bit not set by async write");
  a_commit_edges: assert property ($fell(busy_reg[timer_async_pkg::IDX_CMP_B]) && $past(async_sel_reg)
    |-> $past(tosc_rise) && $past(edge_reg[timer_async_pkg::IDX_CMP_B]) == 2'h1)
    else $error("compare b transfer not on second oscillator edge");

  // ----------------------------------------
  // control and compare registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_reg <= timer_async_pkg::RST_BYTE;
      ctrl_b_reg <= timer_async_pkg::RST_BYTE;
    end else begin
      if (commit[timer_async_pkg::IDX_CTRL_A]) begin
        ctrl_a_reg <= commit_val[timer_async_pkg::IDX_CTRL_A] & timer_async_pkg::CTRL_A_MASK;
      end
      if (commit[timer_async_pkg::IDX_CTRL_B]) begin
        ctrl_b_reg <= commit_val[timer_async_pkg::IDX_CTRL_B] & timer_async_pkg::CTRL_B_MASK;
      end
    end
  end

  assign wgm = {ctrl_b_reg.wgm2, ctrl_a_reg.wgm};
  assign pc_mode = (wgm == timer_async_pkg::WGM_PC_MAX) || (wgm == timer_async_pkg::WGM_PC_CMPA);
  // code 5 takes its top from compare a, code 1 runs to max
  assign top = ctrl_b_reg.wgm2 ? act_reg[0] : timer_async_pkg::MAX;
  assign at_top = ~down_reg & (cnt_reg == top);

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // 255 up steps plus 255 down steps give the 510-clock period
  always_comb begin
    cnt_next = cnt_reg;
    down_next = down_reg;
    if (tick) begin
      if (!pc_mode) begin
        cnt_next = cnt_reg + 8'h01;
        down_next = 1'b0;
      end else if (!down_reg && cnt_reg >= top) begin
        cnt_next = (top == timer_async_pkg::BOTTOM) ? timer_async_pkg::BOTTOM : cnt_reg - 8'h01;
        down_next = 1'b1;
      end else if (down_reg && cnt_reg == timer_async_pkg::BOTTOM) begin
        cnt_next = cnt_reg + 8'h01;
        down_next = 1'b0;
      end else if (down_reg) begin
        cnt_next = cnt_reg - 8'h01;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= timer_async_pkg::BOTTOM;
      down_reg <= 1'b0;
    end else if (commit[timer_async_pkg::IDX_CNT]) begin
      cnt_reg <= commit_val[timer_async_pkg::IDX_CNT];
    end else begin
      cnt_reg <= cnt_next;
      down_reg <= down_next;
    end
  end

  // read copy only moves on oscillator edges while asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_rd_reg <= timer_async_pkg::BOTTOM;
    end else if (!async_sel_reg || tosc_rise) begin
      cnt_rd_reg <= cnt_reg;
    end
  end

  a_top_reverse: assert property (tick && pc_mode && at_top && top != timer_async_pkg::BOTTOM
    && !commit[timer_async_pkg::IDX_CNT] |=> down_reg && cnt_reg == $past(top) - 8'h01)
    else $error("counter did not reverse after one clock at top");
  a_max_top: assert property (tick && wgm == timer_async_pkg::WGM_PC_MAX && !down_reg
    && cnt_reg == 8'hfe && !commit[timer_async_pkg::IDX_CNT] |=> !down_reg && cnt_reg == 8'hff)
    else $error("mode 1 did not count up to max");

  // ----------------------------------------
  // compare units
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    assign com[i] = (i == 0) ? ctrl_a_reg.com_a : ctrl_a_reg.com_b;
    assign match[i] = tick & (cnt_reg == act_reg[i]) & ~busy_reg[timer_async_pkg::IDX_CNT]
                      & ~busy_reg[timer_async_pkg::IDX_CMP_A + i];

    // software copy plus the active copy that loads at top in phase-correct modes and every clock otherwise
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cmp_reg[i] <= timer_async_pkg::RST_BYTE;
        act_reg[i] <= timer_async_pkg::RST_BYTE;
      end else begin
        if (commit[timer_async_pkg::IDX_CMP_A + i]) begin
          cmp_reg[i] <= commit_val[timer_async_pkg::IDX_CMP_A + i];
        end
        if (!pc_mode || (tick && at_top)) begin
          act_reg[i] <= cmp_reg[i];
        end
      end
    end

    // compare_outputs flops update on timer ticks only, with no cpu-side resync; the enable flops follow dir_reg, masked while com is off, every clock
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        compare_outputs[i] <= 1'b0;
        compare_outputs_oe_n[i] <= 1'b1;
      end else begin
        compare_outputs_oe_n[i] <= ~(dir_reg[i] & (com[i] != timer_async_pkg::COM_OFF));
        if (tick && pc_mode && com[i][1]) begin
          if (at_top && act_reg[i] == top) begin
            compare_outputs[i] <= ~com[i][0];
          end else if (cnt_reg == timer_async_pkg::BOTTOM) begin
            // keeps the pulse centred even after a missed match
            compare_outputs[i] <= (act_reg[i] == timer_async_pkg::BOTTOM) ? com[i][0] : ~com[i][0];
          end else if (match[i]) begin
            compare_outputs[i] <= down_reg ? ~com[i][0] : com[i][0];
          end
        end else if (match[i] && com[i] == timer_async_pkg::COM_TOGGLE && (!pc_mode || (i == 0 && wgm[2]))) begin
          compare_outputs[i] <= ~compare_outputs[i];
        end
      end
    end
  end

  a_pin_enable: assert property (!dir_reg[0] |=> compare_outputs_oe_n[0])
    else $error("compare pin driven with direction input");
  a_match_blocked: assert property (busy_reg[timer_async_pkg::IDX_CMP_B]
    |-> !match[1])
    else $error("compare match during pending compare write");

  // ----------------------------------------
  // flags and their crossing delay
  // ----------------------------------------
  assign ev[timer_async_pkg::FLAG_OVF] = tick & ~commit[timer_async_pkg::IDX_CNT]
    & (cnt_next == timer_async_pkg::BOTTOM) & (cnt_reg != timer_async_pkg::BOTTOM);
  assign ev[2:1] = match;
  assign ev_cpu = async_sel_reg ? pipe_reg[timer_async_pkg::FLAG_SYNC_CYCLES-1] : ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < timer_async_pkg::FLAG_SYNC_CYCLES; k++) begin
        pipe_reg[k] <= 3'h0;
      end
    end else begin
      pipe_reg[0] <= ev;
      for (int k = 1; k < timer_async_pkg::FLAG_SYNC_CYCLES; k++) begin
        pipe_reg[k] <= pipe_reg[k-1];
      end
    end
  end

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 3'h0;
    end else if (wr_acc && paddr == timer_async_pkg::OFF_FLAGS) begin
      flag_reg <= (flag_reg & ~pwdata[2:0]) | ev_cpu;
    end else begin
      flag_reg <= flag_reg | ev_cpu;
    end
  end

  a_sync_ovf: assert property (ev[timer_async_pkg::FLAG_OVF] && !async_sel_reg
    |=> flag_reg[timer_async_pkg::FLAG_OVF])
    else $error("overflow flag not set at bottom");
  a_async_flag_delay: assert property (ev[timer_async_pkg::FLAG_OVF] && async_sel_reg ##1 async_sel_reg[*3]
    |=> flag_reg[timer_async_pkg::FLAG_OVF])
    else $error("async overflow flag late");

  // ----------------------------------------
  // sleep wake-up and cpu stall
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_arm_reg <= 1'b0;
      wake_req <= 1'b0;
      stall_reg <= 3'h0;
      cpu_stall <= 1'b0;
    end else begin
      if (!sleep_active) begin
        wake_arm_reg <= 1'b0;
        wake_req <= 1'b0;
      end else begin
        if (async_sel_reg && (flag_reg & ien_reg) != 3'h0) begin
          wake_arm_reg <= 1'b1;
        end
        if (wake_arm_reg && src_en) begin
          wake_req <= 1'b1;
        end
      end
      if (sleep_active && wake_arm_reg && src_en && !wake_req) begin
        stall_reg <= timer_async_pkg::WAKE_STALL;
        cpu_stall <= 1'b1;
      end else if (stall_reg != 3'h0) begin
        stall_reg <= stall_reg - 3'h1;
        cpu_stall <= (stall_reg != 3'h1);
      end
    end
  end

  a_wake_stall: assert property ($rose(wake_req) |-> cpu_stall[*4] ##1 !cpu_stall)
    else $error("cpu stall not four cycles after wake");

endmodule

// *** verilog/timer_async_pkg.sv ***
// constants and carriers for the asynchronous phase-correct pwm timer
package timer_async_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNTER = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0c;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_ASYNC = 8'h14;
  localparam logic [7:0] OFF_GTC = 8'h18;
  localparam logic [7:0] OFF_FLAGS = 8'h1c;
  localparam logic [7:0] OFF_IEN = 8'h20;
  localparam logic [7:0] OFF_DIR = 8'h24;
  // ----------------------------------------
  // holding registers, in busy-bit order
  // ----------------------------------------
  localparam int N_HOLD = 5;
  localparam int IDX_CTRL_A = 0;
  localparam int IDX_CTRL_B = 1;
  localparam int IDX_CNT = 2;
  localparam int IDX_CMP_A = 3;
  localparam int IDX_CMP_B = 4;
  localparam logic [7:0] HOLD_OFF [N_HOLD] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_COUNTER, OFF_CMP_A, OFF_CMP_B};
  // ----------------------------------------
  // field positions, masks and reset values
  // ----------------------------------------
  localparam int ASYNC_SEL_BIT = 5;
  localparam int PSR_BIT = 0;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0f;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ----------------------------------------
  // modes, counter limits and timing
  // ----------------------------------------
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_PC_CMPA = 3'h5;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;
  localparam logic [1:0] COMMIT_EDGES = 2'h2;
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam logic [2:0] WAKE_STALL = 3'h4;
  // prescaler tap masks for select codes 0..7 (0 = stopped)
  localparam logic [9:0] PSC_MASK [8] = '{10'h000, 10'h000, 10'h007, 10'h01f,
                                         10'h03f, 10'h07f, 10'h0ff, 10'h3ff};
  // ----------------------------------------
  // control register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsv;
    logic [1:0] wgm;
  } ctrl_a_t;
  typedef struct packed {
    logic [3:0] rsv;
    logic wgm2;
    logic [2:0] prescale_select;
  } ctrl_b_t;
endpackage

// *** sim/tb_top.sv ***
// self-checking bench for the asynchronous phase-correct pwm timer
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_osc_input = 1'b0;
  logic sleep_active = 1'b0;
  logic osc_halt = 1'b0;
  logic wake_req;
  logic cpu_stall;
  logic [1:0] compare_outputs;
  logic [1:0] compare_outputs_oe_n;
  logic [2:0] osc_div = 3'h0;
  logic [31:0] seed = 32'h3a;
  int mismatches = 0;
  int cmp_count = 0;
  int osc_rises = 0;

  async_timer_phase_correct_pwm u_async_timer_phase_correct_pwm (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_osc_input(timer_osc_input), .sleep_active(sleep_active), .osc_halt(osc_halt),
    .wake_req(wake_req), .cpu_stall(cpu_stall), .compare_outputs(compare_outputs),
    .compare_outputs_oe_n(compare_outputs_oe_n)
  );

  always #50 clk = ~clk;

  // oscillator at an eighth of the cpu clock, well under the quarter limit
  always @(posedge clk) begin
    osc_div <= osc_div + 3'h1;
    timer_osc_input <= osc_div[2];
  end

  always @(posedge timer_osc_input) begin
    osc_rises++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & mask, exp);
  endtask

  task automatic high_chk(input int ch, input int cycles, input logic [31:0] exp);
    int i;
    int n;
    n = 0;
    for (i = 0; i < cycles; i++) begin
      @(posedge clk);
      if (compare_outputs[ch] === 1'b1) n++;
    end
    chk(32'(n), exp);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // non-inverted output is high for twice the compare value in each period
  function automatic logic [31:0] exp_high(input logic [1:0] act, input int c, input int span, input int n);
    return (act == 2'h2) ? 32'(2 * c * n) : 32'((span - 2 * c) * n);
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    logic [7:0] c;
    logic [1:0] act;
    int k;
    int n;
    int r0;
    repeat (8) @(posedge clk);
    chk({30'h0, compare_outputs_oe_n}, 32'h3);
    rst_n <= 1'b1;
    rd_chk(timer_async_pkg::OFF_CTRL_A, 32'hffffffff, 32'h0);
    rd_chk(timer_async_pkg::OFF_ASYNC, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h28, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(timer_async_pkg::OFF_DIR, 32'h3);
    // mode 1: corners of the compare value, both polarities, two prescalers
    for (k = 0; k < 6; k++) begin
      seed = xs(seed);
      c = (k == 0 || k == 2) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
      act = (k == 2 || k == 4) ? 2'h3 : 2'h2;
      n = (k == 5) ? 8 : 1;
      wr(timer_async_pkg::OFF_CMP_A, {24'h0, c});
      wr(timer_async_pkg::OFF_CMP_B, {24'h0, c});
      wr(timer_async_pkg::OFF_CTRL_A, {24'h0, act, act, 4'h1});
      wr(timer_async_pkg::OFF_CTRL_B, (k == 5) ? 32'h2 : 32'h1);
      repeat (1020 * n) @(posedge clk);
      high_chk(0, 510 * n, exp_high(act, int'(c), 510, n));
      high_chk(1, 510 * n, exp_high(act, int'(c), 510, n));
    end
    rd_chk(timer_async_pkg::OFF_FLAGS, 32'h1, 32'h1);
    // stop the counter so no new bottom can race the clear below
    wr(timer_async_pkg::OFF_CTRL_B, 32'h0);
    wr(timer_async_pkg::OFF_GTC, 32'h1);
    wr(timer_async_pkg::OFF_FLAGS, 32'h7);
    rd_chk(timer_async_pkg::OFF_FLAGS, 32'h1, 32'h0);
    wr(timer_async_pkg::OFF_DIR, 32'h1);
    repeat (2) @(posedge clk);
    chk({30'h0, compare_outputs_oe_n}, 32'h2);
    // mode 5: compare a sets the top, channel b runs pwm below it
    wr(timer_async_pkg::OFF_DIR, 32'h3);
    wr(timer_async_pkg::OFF_CMP_A, 32'h64);
    wr(timer_async_pkg::OFF_CMP_B, 32'h1e);
    wr(timer_async_pkg::OFF_CTRL_A, 32'h21);
    wr(timer_async_pkg::OFF_CTRL_B, 32'h9);
    // old top must be reached and a full descent passed before the pattern repeats
    repeat (1000) @(posedge clk);
    high_chk(1, 200, exp_high(2'h2, 30, 200, 1));
    // asynchronous clocking: holding register and busy bit
    wr(timer_async_pkg::OFF_ASYNC, 32'h20);
    r0 = osc_rises;
    wr(timer_async_pkg::OFF_CMP_B, 32'h50);
    rd_chk(timer_async_pkg::OFF_ASYNC, 32'hffffffff, 32'h30);
    for (k = 0; k < 40; k++) begin
      apb(1'b0, timer_async_pkg::OFF_ASYNC, 32'h0, q, e);
      if (q[4] === 1'b0) break;
    end
    chk(32'(k < 40), 32'h1);
    chk(32'((osc_rises - r0) >= 2 && (osc_rises - r0) <= 4), 32'h1);
    rd_chk(timer_async_pkg::OFF_CMP_B, 32'hff, 32'h50);
    // halted oscillator: counter read copy must stay frozen
    osc_halt <= 1'b1;
    repeat (20) @(posedge clk);
    apb(1'b0, timer_async_pkg::OFF_COUNTER, 32'h0, q, e);
    repeat (40) @(posedge clk);
    rd_chk(timer_async_pkg::OFF_COUNTER, 32'hff, q);
    osc_halt <= 1'b0;
    // sleep with a pending enabled overflow flag: wake on an oscillator edge, stall four cycles
    wr(timer_async_pkg::OFF_IEN, 32'h1);
    sleep_active <= 1'b1;
    for (k = 0; k < 40 && wake_req !== 1'b1; k++) @(posedge clk);
    chk({31'h0, wake_req}, 32'h1);
    n = 0;
    for (k = 0; k < 8; k++) begin
      if (cpu_stall === 1'b1) n++;
      @(posedge clk);
    end
    chk(32'(n), 32'h4);
    sleep_active <= 1'b0;
    stop_test();
  end
endmodule
